// file: verilog/rx_ctrl_pkg.sv
// constants, types and register map for the serial receiver control block
package rx_ctrl_pkg;

  localparam int ADDR_W     = 15;
  localparam int DATA_W     = 8;
  localparam int PARAM_REGS = 11;

  // register offsets
  localparam logic [ADDR_W-1:0] OFS_TUNE_A   = 15'h02AB;
  localparam logic [ADDR_W-1:0] OFS_CAL_B    = 15'h02AE;
  localparam logic [ADDR_W-1:0] OFS_TUNE_C   = 15'h02B1;
  localparam logic [ADDR_W-1:0] OFS_TUNE_D   = 15'h02B2;
  localparam logic [ADDR_W-1:0] OFS_GEN_CTRL = 15'h0300;

  // address window steered by the link page bit
  localparam logic [ADDR_W-1:0] PAGE_LO = 15'h0401;
  localparam logic [ADDR_W-1:0] PAGE_HI = 15'h047E;

  // reset values
  localparam logic [DATA_W-1:0] RST_TUNE_A   = 8'h93;
  localparam logic [DATA_W-1:0] RST_TUNE_C   = 8'hC3;
  localparam logic [DATA_W-1:0] RST_TUNE_D   = 8'h93;
  localparam logic [DATA_W-1:0] RST_CAL_B    = 8'h00;
  localparam logic [DATA_W-1:0] RST_GEN_CTRL = 8'h00;
  localparam logic [DATA_W-1:0] ZERO_BYTE    = 8'h00;

  // writable bit masks; reserved bits are held at zero
  localparam logic [DATA_W-1:0] MASK_CAL_B    = 8'h01;
  localparam logic [DATA_W-1:0] MASK_GEN_CTRL = 8'h4F;

  // field positions
  localparam int CAL_BIT       = 0;
  localparam int CSUM_BIT      = 6;
  localparam int LINK_MODE_BIT = 3;
  localparam int LINK_PAGE_BIT = 2;
  localparam int LINK_EN_LSB   = 0;
  localparam int LINK_EN_W     = 2;

  // serial frame layout: read flag, 15-bit address, then one data byte, msb first
  localparam int          CNT_W      = 4;
  localparam logic [CNT_W-1:0] INSTR_LAST = 4'hF;
  localparam logic [CNT_W-1:0] DATA_LAST  = 4'h7;
  localparam logic [CNT_W-1:0] CNT_ZERO   = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ONE    = 4'h1;
  localparam int          RW_BIT     = 15;

  typedef enum logic [1:0] {PH_INSTR, PH_DATA, PH_DONE} phase_type;

  // packed link configuration bytes, element 0 is the lowest address
  typedef struct packed {
    logic [PARAM_REGS-1:0][DATA_W-1:0] reg_byte;
  } link_params_type;

  // access handed on to registers outside this block
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              link_sel;
  } ext_bus_type;

  // termination trim values driven to the lane analog
  typedef struct packed {
    logic [DATA_W-1:0] tune_a;
    logic [DATA_W-1:0] tune_c;
    logic [DATA_W-1:0] tune_d;
  } term_tune_type;

endpackage : rx_ctrl_pkg

// file: verilog/param_checksum.sv
// link parameter checksum, by fields or by packed bytes
`timescale 1ns/1ps
module param_checksum
  import rx_ctrl_pkg::*;
(
  input  wire logic            by_bytes,
  input  wire link_params_type params,
  output logic [DATA_W-1:0]    sum
);

  logic [DATA_W-1:0] field_sum;
  logic [DATA_W-1:0] byte_sum;

  // sum of the individual configuration fields, each at its own width
  always_comb
  begin
    field_sum = params.reg_byte[0];
    field_sum = field_sum + {4'h0, params.reg_byte[1][3:0]};
    field_sum = field_sum + {3'h0, params.reg_byte[2][4:0]};
    field_sum = field_sum + {7'h00, params.reg_byte[3][7]};
    field_sum = field_sum + {3'h0, params.reg_byte[3][4:0]};
    field_sum = field_sum + params.reg_byte[4];
    field_sum = field_sum + {3'h0, params.reg_byte[5][4:0]};
    field_sum = field_sum + params.reg_byte[6];
    field_sum = field_sum + {6'h00, params.reg_byte[7][7:6]};
    field_sum = field_sum + {3'h0, params.reg_byte[7][4:0]};
    field_sum = field_sum + {5'h00, params.reg_byte[8][7:5]};
    field_sum = field_sum + {3'h0, params.reg_byte[8][4:0]};
    field_sum = field_sum + {5'h00, params.reg_byte[9][7:5]};
    field_sum = field_sum + {3'h0, params.reg_byte[9][4:0]};
    field_sum = field_sum + {7'h00, params.reg_byte[10][7]};
    field_sum = field_sum + {3'h0, params.reg_byte[10][4:0]};
  end

  // plain byte sum, the 8-bit adder wraps modulo 256
  always_comb
  begin
    byte_sum = ZERO_BYTE;
    for (int i = 0; i < PARAM_REGS; i++)
    begin
      byte_sum = byte_sum + params.reg_byte[i];
    end
  end

  assign sum = by_bytes ? byte_sum : field_sum;

endmodule : param_checksum

// file: verilog/serial_link_receiver_control.sv
// receiver control registers behind the serial configuration port
//
// Behaviour
// - rising edge of calibrate bit starts calibration of lanes two to five.
// - reserved control bits read zero and ignore writes.
// - checksum method bit picks how the stored local checksum is computed.
// - method 0 sums the individual link configuration fields.
// - method 1 sums the packed parameter bytes modulo 256.
// - topology bit selects single link at 0, dual link at 1.
// - page bit exposes link 0 or link 1 register map.
// - paging touches only addresses 0x401 to 0x47E.
// - enable bits bring up the receiver logic per link.
// - enable field 11 both, 01 link 0, 10 link 1, 00 none.
`timescale 1ns/1ps
module serial_link_receiver_control
  import rx_ctrl_pkg::*;
(
  input  wire logic                 mclk,
  input  wire logic                 arst_n,
  input  wire logic                 spi_sclk,
  input  wire logic                 spi_cs_n,
  input  wire logic                 spi_sdio_in,
  output logic                      spi_sdio_out,
  output logic                      spi_sdio_oe,
  output ext_bus_type               ext_req,
  input  wire logic [DATA_W-1:0]    ext_rdata,
  input  wire link_params_type      link_params,
  output term_tune_type             term_tune,
  output logic                      term_calibrate_group_b,
  output logic                      checksum_by_bytes,
  output logic                      link_mode_dual,
  output logic                      link_page,
  output logic [LINK_EN_W-1:0]      link_enable,
  output logic [DATA_W-1:0]         computed_param_sum_store
);

  // pin synchronisers: three stages, a change counts once stages two and three agree
  logic [2:0] sclk_sync_q, cs_sync_q, sdi_sync_q;
  logic       sclk_f_q, cs_f_q, sdi_f_q;
  logic       sclk_f_d, cs_f_d, sdi_f_d;
  logic       sclk_rise, sclk_fall;

  always_comb
  begin
    sclk_f_d = (sclk_sync_q[1] == sclk_sync_q[2]) ? sclk_sync_q[2] : sclk_f_q;
    cs_f_d   = (cs_sync_q[1] == cs_sync_q[2]) ? cs_sync_q[2] : cs_f_q;
    sdi_f_d  = (sdi_sync_q[1] == sdi_sync_q[2]) ? sdi_sync_q[2] : sdi_f_q;
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sclk_sync_q <= 3'h0;
      cs_sync_q   <= 3'h7;
      sdi_sync_q  <= 3'h0;
      sclk_f_q    <= 1'b0;
      cs_f_q      <= 1'b1;
      sdi_f_q     <= 1'b0;
    end
    else
    begin
      sclk_sync_q <= {sclk_sync_q[1:0], spi_sclk};
      cs_sync_q   <= {cs_sync_q[1:0], spi_cs_n};
      sdi_sync_q  <= {sdi_sync_q[1:0], spi_sdio_in};
      sclk_f_q    <= sclk_f_d;
      cs_f_q      <= cs_f_d;
      sdi_f_q     <= sdi_f_d;
    end
  end

  // data is sampled on the filtered rising edge, so the bit must be stable with it
  assign sclk_rise = sclk_f_d & ~sclk_f_q;
  assign sclk_fall = ~sclk_f_d & sclk_f_q;

  // frame engine state
  phase_type          phase_q, phase_d;
  logic [CNT_W-1:0]   cnt_q, cnt_d;
  logic [15:0]        instr_q, instr_d;
  logic [DATA_W-1:0]  sh_out_q, sh_out_d;
  logic               oe_q, oe_d;
  ext_bus_type        ext_q, ext_d;

  // local register state
  term_tune_type      tune_q, tune_d;
  logic [DATA_W-1:0]  cal_q, cal_d;
  logic [DATA_W-1:0]  gen_q, gen_d;
  logic               cal_pulse_q, cal_pulse_d;
  logic [DATA_W-1:0]  csum_q;
  logic [DATA_W-1:0]  csum_now;

  logic [ADDR_W-1:0]  acc_addr;
  logic [DATA_W-1:0]  wr_byte;
  logic               is_local;
  logic               in_page;
  logic [DATA_W-1:0]  local_rdata;

  // next instruction word once the current edge shifts in
  assign acc_addr = instr_d[ADDR_W-1:0];
  assign wr_byte  = {sh_out_q[DATA_W-2:0], sdi_f_d};
  assign in_page  = (acc_addr >= PAGE_LO) && (acc_addr <= PAGE_HI);

  // local read mux; unmapped local bits are zero
  always_comb
  begin
    is_local    = 1'b1;
    local_rdata = ZERO_BYTE;
    unique case (acc_addr)
      OFS_TUNE_A:   local_rdata = tune_q.tune_a;
      OFS_CAL_B:    local_rdata = cal_q;
      OFS_TUNE_C:   local_rdata = tune_q.tune_c;
      OFS_TUNE_D:   local_rdata = tune_q.tune_d;
      OFS_GEN_CTRL: local_rdata = gen_q;
      default:      is_local    = 1'b0;
    endcase
  end

  // frame sequencing, register writes and hand-off of foreign addresses
  always_comb
  begin
    phase_d     = phase_q;
    cnt_d       = cnt_q;
    instr_d     = instr_q;
    sh_out_d    = sh_out_q;
    oe_d        = oe_q;
    ext_d       = ext_q;
    ext_d.wr    = 1'b0;
    ext_d.rd    = 1'b0;
    tune_d      = tune_q;
    cal_d       = cal_q;
    gen_d       = gen_q;
    cal_pulse_d = 1'b0;
    if (cs_f_q)
    begin
      // deselect aborts any partial frame
      phase_d = PH_INSTR;
      cnt_d   = CNT_ZERO;
      oe_d    = 1'b0;
    end
    else
    begin
      unique case (phase_q)
        PH_INSTR:
        begin
          if (sclk_rise)
          begin
            instr_d = {instr_q[14:0], sdi_f_d};
            cnt_d   = cnt_q + CNT_ONE;
            if (cnt_q == INSTR_LAST)
            begin
              phase_d    = PH_DATA;
              cnt_d      = CNT_ZERO;
              sh_out_d   = ZERO_BYTE;
              ext_d.addr = acc_addr;
              // page steering applies only inside its window
              ext_d.link_sel = in_page & gen_q[LINK_PAGE_BIT];
              if (instr_d[RW_BIT])
              begin
                oe_d     = 1'b1;
                sh_out_d = is_local ? local_rdata : ext_rdata;
                ext_d.rd = ~is_local;
              end
            end
          end
        end
        PH_DATA:
        begin
          if (instr_q[RW_BIT])
          begin
            // read: bit 7 already stands from the instruction end, so the fall after
            // the last instruction rise must not shift or the msb would be lost
            if (sclk_fall && (cnt_q != CNT_ZERO))
            begin
              sh_out_d = {sh_out_q[DATA_W-2:0], 1'b0};
            end
            if (sclk_rise)
            begin
              cnt_d = cnt_q + CNT_ONE;
              if (cnt_q == DATA_LAST)
              begin
                phase_d = PH_DONE;
              end
            end
          end
          else if (sclk_rise)
          begin
            sh_out_d = wr_byte;
            cnt_d    = cnt_q + CNT_ONE;
            if (cnt_q == DATA_LAST)
            begin
              phase_d = PH_DONE;
              unique case (ext_q.addr)
                OFS_TUNE_A: tune_d.tune_a = wr_byte;
                OFS_TUNE_C: tune_d.tune_c = wr_byte;
                OFS_TUNE_D: tune_d.tune_d = wr_byte;
                OFS_CAL_B:
                begin
                  cal_d       = wr_byte & MASK_CAL_B;
                  cal_pulse_d = wr_byte[CAL_BIT] & ~cal_q[CAL_BIT];
                end
                OFS_GEN_CTRL: gen_d = wr_byte & MASK_GEN_CTRL;
                default:
                begin
                  ext_d.wr    = 1'b1;
                  ext_d.wdata = wr_byte;
                end
              endcase
            end
          end
        end
        PH_DONE:
        begin
          // one byte per frame; stop driving once the byte is out
          if (sclk_fall)
          begin
            oe_d = 1'b0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      phase_q     <= PH_INSTR;
      cnt_q       <= CNT_ZERO;
      instr_q     <= 16'h0000;
      sh_out_q    <= ZERO_BYTE;
      oe_q        <= 1'b0;
      ext_q       <= '0;
      tune_q      <= {RST_TUNE_A, RST_TUNE_C, RST_TUNE_D};
      cal_q       <= RST_CAL_B;
      gen_q       <= RST_GEN_CTRL;
      cal_pulse_q <= 1'b0;
    end
    else
    begin
      phase_q     <= phase_d;
      cnt_q       <= cnt_d;
      instr_q     <= instr_d;
      sh_out_q    <= sh_out_d;
      oe_q        <= oe_d;
      ext_q       <= ext_d;
      tune_q      <= tune_d;
      cal_q       <= cal_d;
      gen_q       <= gen_d;
      cal_pulse_q <= cal_pulse_d;
    end
  end

  // checksum recomputed every cycle so it tracks parameter and method changes
  param_checksum u_checksum
  (
    .by_bytes (gen_q[CSUM_BIT]),
    .params   (link_params),
    .sum      (csum_now)
  );

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      csum_q <= ZERO_BYTE;
    end
    else
    begin
      csum_q <= csum_now;
    end
  end

  // outputs straight from registers
  assign spi_sdio_out             = sh_out_q[DATA_W-1];
  assign spi_sdio_oe              = oe_q;
  assign ext_req                  = ext_q;
  assign term_tune                = tune_q;
  assign term_calibrate_group_b   = cal_pulse_q;
  assign checksum_by_bytes        = gen_q[CSUM_BIT];
  assign link_mode_dual           = gen_q[LINK_MODE_BIT];
  assign link_page                = gen_q[LINK_PAGE_BIT];
  // each bit enables its own link, so 11 both, 01 link 0, 10 link 1
  assign link_enable              = gen_q[LINK_EN_LSB +: LINK_EN_W];
  assign computed_param_sum_store = csum_q;

endmodule : serial_link_receiver_control

// file: tb/rx_ctrl_checker.sv
// port assertions for the receiver control block
`timescale 1ns/1ps
module rx_ctrl_checker
  import rx_ctrl_pkg::*;
(
  input wire logic                 mclk,
  input wire logic                 arst_n,
  input wire logic                 spi_cs_n,
  input wire ext_bus_type          ext_req,
  input wire link_params_type      link_params,
  input wire term_tune_type        term_tune,
  input wire logic                 term_calibrate_group_b,
  input wire logic                 checksum_by_bytes,
  input wire logic                 link_page,
  input wire logic [LINK_EN_W-1:0] link_enable,
  input wire logic [DATA_W-1:0]    computed_param_sum_store
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  logic [PARAM_REGS-1:0][DATA_W-1:0] pb;
  logic [DATA_W-1:0]                 bsum;
  logic [DATA_W-1:0]                 fsum;
  logic                              in_win;
  // reference sums; the 8-bit width gives the modulo 256 wrap for free
  always_comb
  begin
    pb = link_params.reg_byte;
    bsum = '0;
    for (int i = 0; i < PARAM_REGS; i++)
      bsum = bsum + pb[i];
    fsum = pb[0] + pb[1][3:0] + pb[2][4:0] + pb[3][7] + pb[3][4:0] + pb[4] + pb[5][4:0] + pb[6]
         + pb[7][7:6] + pb[7][4:0] + pb[8][7:5] + pb[8][4:0] + pb[9][7:5] + pb[9][4:0]
         + pb[10][7] + pb[10][4:0];
    in_win = (ext_req.addr >= PAGE_LO) && (ext_req.addr <= PAGE_HI);
  end
  a_cal_one_cycle: assert property (term_calibrate_group_b |=> !term_calibrate_group_b)
    else $error("calibrate pulse longer than one cycle");
  a_cal_from_write: assert property (term_calibrate_group_b |-> ext_req.addr == OFS_CAL_B)
    else $error("calibrate pulse without calibrate access");
  a_trim_reset_value: assert property ($rose(arst_n) |-> term_tune == {8'h93, 8'hC3, 8'h93})
    else $error("trim values wrong after reset");
  a_bytes_sum: assert property (checksum_by_bytes |=> computed_param_sum_store == $past(bsum))
    else $error("byte checksum wrong");
  a_field_sum: assert property (!checksum_by_bytes |=> computed_param_sum_store == $past(fsum))
    else $error("field checksum wrong");
  a_page_window: assert property (ext_req.link_sel |-> in_win)
    else $error("link select outside paged window");
  a_page_follow: assert property (in_win |-> ext_req.link_sel == link_page)
    else $error("link select differs from page bit");
  a_enable_source: assert property (!$stable(link_enable) |-> ext_req.addr == OFS_GEN_CTRL)
    else $error("link enable moved without control access");
  a_idle_hold: assert property (spi_cs_n [*8] |=> $stable(term_tune) && $stable(link_page))
    else $error("register changed while port idle");
  c_cal: cover property (term_calibrate_group_b);
  c_sel: cover property (ext_req.link_sel && ext_req.wr);
  c_both: cover property (link_enable == 2'b11);
endmodule : rx_ctrl_checker

bind serial_link_receiver_control rx_ctrl_checker rx_ctrl_checker_inst (.mclk, .arst_n, .spi_cs_n,
  .ext_req, .link_params, .term_tune, .term_calibrate_group_b, .checksum_by_bytes, .link_page,
  .link_enable, .computed_param_sum_store);

// file: tb/serial_link_receiver_control_tb.sv
// self-checking bench for the receiver control block
`timescale 1ns/1ps
module serial_link_receiver_control_tb import rx_ctrl_pkg::*;;
  logic              mclk = 1'b0;
  logic              arst_n = 1'b0;
  logic              sclk = 1'b0;
  logic              cs_n = 1'b1;
  logic              sdi = 1'b0;
  logic              sdo;
  logic              sdo_oe;
  ext_bus_type       ext_req;
  ext_bus_type       wr_seen;
  logic [7:0]        ext_rdata = 8'h00;
  link_params_type   link_params = '0;
  term_tune_type     term_tune;
  logic              cal;
  logic              by_bytes;
  logic              dual;
  logic              page;
  logic [1:0]        link_en;
  logic [7:0]        csum;
  logic [7:0]        rv;
  int                n_fail = 0;
  int                checked = 0;
  int                n_cal = 0;
  int                n_rd = 0;

  serial_link_receiver_control serial_link_receiver_control_inst (.mclk(mclk), .arst_n(arst_n),
    .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_sdio_in(sdo_oe ? sdo : sdi), .spi_sdio_out(sdo),
    .spi_sdio_oe(sdo_oe), .ext_req(ext_req), .ext_rdata(ext_rdata), .link_params(link_params),
    .term_tune(term_tune), .term_calibrate_group_b(cal), .checksum_by_bytes(by_bytes),
    .link_mode_dual(dual), .link_page(page), .link_enable(link_en), .computed_param_sum_store(csum));

  always #2.5 mclk = ~mclk;

  // record pulses and outgoing writes
  always @(posedge mclk)
  begin
    if (cal)
      n_cal <= n_cal + 1;
    if (ext_req.wr)
      wr_seen <= ext_req;
    if (ext_req.rd)
      n_rd <= n_rd + 1;
  end

  task chk(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t %s seen %h exp %h", $time, msg, seen, exp);
    end
  endtask : chk

  // one frame; each sclk level lasts 5 cycles so the 3-flop filter sees it
  task xfer(input logic [23:0] f);
    rv = 8'h00;
    cs_n <= 1'b0;
    for (int i = 23; i >= 0; i--)
    begin
      sdi <= f[i];
      repeat (5) @(posedge mclk);
      if (i < 8)
        rv[i] = sdo;
      sclk <= 1'b1;
      repeat (5) @(posedge mclk);
      sclk <= 1'b0;
    end
    repeat (8) @(posedge mclk);
    cs_n <= 1'b1;
    repeat (8) @(posedge mclk);
  endtask : xfer

  task wr(input logic [14:0] a, input logic [7:0] d);
    xfer({1'b0, a, d});
  endtask : wr

  task rchk(input logic [14:0] a, input logic [7:0] e, input string msg);
    xfer({1'b1, a, 8'h00});
    chk(rv, e, msg);
  endtask : rchk

  task t_reset;
    rchk(OFS_TUNE_A, 8'h93, "tune a");
    rchk(OFS_CAL_B, 8'h00, "cal");
    rchk(OFS_TUNE_C, 8'hC3, "tune c");
    rchk(OFS_TUNE_D, 8'h93, "tune d");
    rchk(OFS_GEN_CTRL, 8'h00, "ctrl");
    $display("done reset");
  endtask : t_reset

  task t_trim;
    wr(OFS_TUNE_A, 8'h87);
    wr(OFS_TUNE_C, 8'hB7);
    wr(OFS_TUNE_D, 8'h87);
    rchk(OFS_TUNE_A, 8'h87, "tune a");
    rchk(OFS_TUNE_C, 8'hB7, "tune c");
    rchk(OFS_TUNE_D, 8'h87, "tune d");
    chk(term_tune.tune_a, 8'h87, "tune a pin");
    chk(term_tune.tune_c, 8'hB7, "tune c pin");
    chk(term_tune.tune_d, 8'h87, "tune d pin");
    $display("done trim");
  endtask : t_trim

  // only a 0 to 1 change of the stored bit may start calibration
  task t_cal;
    wr(OFS_CAL_B, 8'hFF);
    chk(8'(n_cal), 8'h01, "first pulse");
    rchk(OFS_CAL_B, 8'h01, "cal reserved");
    wr(OFS_CAL_B, 8'h01);
    chk(8'(n_cal), 8'h01, "no pulse");
    wr(OFS_CAL_B, 8'h00);
    wr(OFS_CAL_B, 8'h01);
    chk(8'(n_cal), 8'h02, "second pulse");
    $display("done cal");
  endtask : t_cal

  task t_ctrl;
    wr(OFS_GEN_CTRL, 8'hFF);
    rchk(OFS_GEN_CTRL, 8'h4F, "ctrl reserved");
    for (int v = 0; v < 4; v++)
    begin
      wr(OFS_GEN_CTRL, 8'(v));
      chk(8'(link_en), 8'(v), "link enable");
    end
    chk(8'(dual), 8'h00, "single");
    wr(OFS_GEN_CTRL, 8'h08);
    chk(8'(dual), 8'h01, "dual");
    $display("done ctrl");
  endtask : t_ctrl

  task t_csum;
    for (int i = 0; i < PARAM_REGS; i++)
      link_params.reg_byte[i] <= 8'hF0 + 8'(i);
    wr(OFS_GEN_CTRL, 8'h40);
    chk(8'(by_bytes), 8'h01, "method");
    chk(csum, 8'h87, "byte sum");
    wr(OFS_GEN_CTRL, 8'h00);
    chk(csum, 8'h8A, "field sum");
    $display("done csum");
  endtask : t_csum

  task t_page;
    ext_rdata <= 8'hA5;
    wr(OFS_GEN_CTRL, 8'h04);
    chk(8'(page), 8'h01, "page bit");
    wr(15'h0401, 8'h5A);
    chk({7'h00, wr_seen.link_sel}, 8'h01, "page low");
    chk(wr_seen.addr[7:0], 8'h01, "ext addr");
    rchk(15'h047E, 8'hA5, "ext read");
    chk(8'(n_rd), 8'h01, "ext read strobes");
    chk({7'h00, ext_req.link_sel}, 8'h01, "page high");
    wr(15'h047F, 8'h3C);
    chk({wr_seen.link_sel, wr_seen.wdata[6:0]}, 8'h3C, "above window");
    wr(OFS_GEN_CTRL, 8'h00);
    wr(15'h0401, 8'h66);
    chk({wr_seen.link_sel, wr_seen.wdata[6:0]}, 8'h66, "page zero");
    $display("done page");
  endtask : t_page

  task final_report;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : final_report

  initial
  begin
    repeat (16) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (8) @(posedge mclk);
    t_reset;
    t_trim;
    t_cal;
    t_ctrl;
    t_csum;
    t_page;
    final_report;
  end
endmodule : serial_link_receiver_control_tb
